// ---- src/sfo_defines.svh ----
// Constants for the sample FIFO and serial output port
`ifndef SFO_DEFINES_SVH
`define SFO_DEFINES_SVH

`define SFO_SAMPLE_W 24
`define SFO_STATUS_W 8
`define SFO_WORD_W 32
`define SFO_FIFO_DEPTH 8
`define SFO_TB_BIT 7
`define SFO_STATUS_RST 8'h00
`define SFO_WORD_RST 32'h0000_0000

`define SFO_CLK_NS 25
`define SFO_T1_NS 60
`define SFO_T8_NS 60
`define SFO_T10_NS 60
`define SFO_T11_NS 90
`define SFO_LEAD_CYC ((`SFO_T1_NS + `SFO_CLK_NS - 1) / `SFO_CLK_NS)
`define SFO_TAIL_CYC ((`SFO_T8_NS + `SFO_CLK_NS - 1) / `SFO_CLK_NS)
`define SFO_TOKGAP_CYC ((`SFO_T10_NS / `SFO_CLK_NS) < 1 ? 1 : (`SFO_T10_NS / `SFO_CLK_NS))
`define SFO_TOKHI_CYC ((`SFO_T11_NS + `SFO_CLK_NS - 1) / `SFO_CLK_NS)

`endif

// ---- src/sfo_pkg.sv ----
// Types for the sample FIFO and serial output port
package sfo_pkg;

   typedef struct packed {
      logic [7:0] status;
      logic [23:0] sample;
   } sfo_word_s;

   typedef enum logic [2:0] {
      PORT_IDLE = 3'b000,
      PORT_LEAD = 3'b001,
      PORT_SHIFT = 3'b011,
      PORT_TAIL = 3'b010,
      PORT_TOKEN = 3'b110
   } sfo_port_e;

endpackage

// ---- src/sfo_sample_fifo.sv ----
// Output FIFO holding combined sample words
`timescale 1ns/1ps
module sfo_sample_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk, // Clock
   input wire logic rst, // Async reset, active high
   input wire logic inValid, // Write request
   output logic inReady, // Not full
   input wire logic [WIDTH-1:0] inData, // Write word
   output logic outValid, // Not empty
   input wire logic outReady, // Read request
   output logic [WIDTH-1:0] outData // Head word
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL = PW'(DEPTH) == '0 ? {1'b1, {PW{1'b0}}} : (PW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wrPtrQ;
   logic [PW-1:0] rdPtrQ;
   logic [PW:0] countQ;
   logic push;
   logic pop;

   function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
      nextPtr = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign inReady = (countQ != FULL);
   assign outValid = (countQ != '0);
   assign outData = mem[rdPtrQ];
   assign push = inValid & inReady;
   assign pop = outReady & outValid;

   // Storage has no reset; only the pointers and the count carry state
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wrPtrQ] <= inData; // [R02]
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wrPtrQ <= '0;
         rdPtrQ <= '0;
         countQ <= '0;
      end else begin
         if (push) begin
            wrPtrQ <= nextPtr(wrPtrQ);
         end
         if (pop) begin
            rdPtrQ <= nextPtr(rdPtrQ);
         end
         countQ <= countQ + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
      end
   end
endmodule

// ---- src/sfo_sample_port.sv ----
// Sample FIFO with token-handshake serial output port
`timescale 1ns/1ps
`include "sfo_defines.svh"

// Behaviour
// R01 - Status byte joined to each 24-bit sample
// R02 - FIFO keeps eight combined words
// R03 - Port sends each 32-bit word, auto or requested
// R04 - Token pulse starts; ready falls before clocking
// R05 - Bit stable around shift clock rising edge
// R06 - Ready rises after last edge; data dropped
// R07 - Token out pulse after ready rises
// R08 - Timing event flags the sample's status
// R09 - Empty FIFO: ready stays high, no transfer
module sfo_sample_port #(
   parameter int DEPTH = `SFO_FIFO_DEPTH,
   parameter int LEAD_CYC = `SFO_LEAD_CYC,
   parameter int TAIL_CYC = `SFO_TAIL_CYC,
   parameter int TOKGAP_CYC = `SFO_TOKGAP_CYC,
   parameter int TOKHI_CYC = `SFO_TOKHI_CYC
) (
   input wire logic ref_clk, // 40 MHz clock
   input wire logic rst, // Async reset, active high
   input wire logic sampleValid, // Filter sample strobe
   output logic sampleReady, // Path can take a sample
   input wire logic [`SFO_SAMPLE_W-1:0] sampleData, // Filtered sample
   input wire logic [`SFO_STATUS_W-2:0] sampleStatus, // Other status bits
   input wire logic timing_event_strobe, // Timing event pin
   input wire logic transfer_token_in, // Request token pin
   input wire logic serial_shift_clock, // Telemetry shift clock pin
   output logic word_ready_n, // Word ready, active low
   output logic serial_sample_line, // Serial data out
   output logic transfer_token_out // Token passed onward
);
   localparam int CW = 3;
   localparam logic [CW-1:0] LEAD_N = CW'(LEAD_CYC - 1);
   localparam logic [CW-1:0] TAIL_N = CW'(TAIL_CYC - 1);
   localparam logic [CW-1:0] GAP_N = CW'(TOKGAP_CYC - 1);
   localparam logic [CW-1:0] TOKHI_N = CW'(TOKHI_CYC - 1);
   localparam logic [CW-1:0] TOKEN_LAST = GAP_N + TOKHI_N + CW'(1);
   localparam logic [5:0] LAST_BIT = 6'(`SFO_WORD_W - 1);

   // =====================================
   // Pin synchronisers
   logic [1:0] eventSyncQ;
   logic [1:0] tokenSyncQ;
   logic [1:0] sclkSyncQ;
   logic eventLastQ;
   logic sclkLastQ;
   logic eventRise;
   logic sclkRise;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         eventSyncQ <= 2'b00;
         tokenSyncQ <= 2'b00;
         sclkSyncQ <= 2'b00;
      end else begin
         eventSyncQ <= {eventSyncQ[0], timing_event_strobe};
         tokenSyncQ <= {tokenSyncQ[0], transfer_token_in};
         sclkSyncQ <= {sclkSyncQ[0], serial_shift_clock};
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         eventLastQ <= 1'b0;
         sclkLastQ <= 1'b0;
      end else begin
         eventLastQ <= eventSyncQ[1];
         sclkLastQ <= sclkSyncQ[1];
      end
   end

   // Edge found on the synchronised level, never on the raw pin
   function automatic logic riseOf(input logic now, input logic last);
      riseOf = now & ~last;
   endfunction

   assign eventRise = riseOf(eventSyncQ[1], eventLastQ);
   assign sclkRise = riseOf(sclkSyncQ[1], sclkLastQ);

   // =====================================
   // Timing event flag
   // Pending flag covers the period up to the next sample; an event in
   // the very cycle of the sample counts for that sample.
   logic eventPendQ;
   logic sampleTaken;
   logic tbFlag;

   assign sampleTaken = sampleValid & sampleReady;
   assign tbFlag = eventPendQ | eventRise; // [R08]

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         eventPendQ <= 1'b0;
      end else if (sampleTaken) begin
         eventPendQ <= 1'b0; // [R08]
      end else if (eventRise) begin
         eventPendQ <= 1'b1; // [R08]
      end
   end

   // =====================================
   // Word assembly and buffering
   sfo_pkg::sfo_word_s inWord;
   sfo_pkg::sfo_word_s headWord;
   logic [`SFO_WORD_W-1:0] bufData;
   logic bufValid;
   logic bufReady;
   logic fifoValid;
   logic [`SFO_WORD_W-1:0] fifoData;
   logic fifoPop;
   logic skidReady;

   always_comb begin
      inWord.sample = sampleData; // [R01]
      inWord.status = {tbFlag, sampleStatus}; // [R01]
   end

   sfo_skid_buf #(
      .WIDTH(`SFO_WORD_W)
   ) u_skid (
      .ref_clk(ref_clk),
      .rst(rst),
      .inValid(sampleValid),
      .inReady(skidReady),
      .inData(inWord),
      .outValid(bufValid),
      .outReady(bufReady),
      .outData(bufData)
   );

   sfo_sample_fifo #(
      .WIDTH(`SFO_WORD_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .rst(rst),
      .inValid(bufValid),
      .inReady(bufReady),
      .inData(bufData),
      .outValid(fifoValid),
      .outReady(fifoPop),
      .outData(fifoData)
   );

   assign sampleReady = skidReady;
   assign headWord = fifoData;

   // =====================================
   // Serial port state machine
   // Token input is taken as a level: tied high it runs the port
   // automatically, pulsed it requests one word.
   sfo_pkg::sfo_port_e stateQ;
   logic [CW-1:0] waitQ;
   logic [5:0] bitQ;
   logic [`SFO_WORD_W-1:0] shiftQ;
   logic startReq;
   logic lastEdge;
   logic shiftStep;
   logic leadEnd;
   logic tailEnd;
   logic tokenEnd;
   logic tokenWindow;
   logic lineActive;

   // Timed state has used up its count
   function automatic logic waitEnd(input sfo_pkg::sfo_port_e st,
                                    input sfo_pkg::sfo_port_e want,
                                    input logic [CW-1:0] cnt,
                                    input logic [CW-1:0] lim);
      waitEnd = (st == want) && (cnt == lim);
   endfunction

   assign startReq = tokenSyncQ[1] & fifoValid; // [R03] [R09]
   assign shiftStep = (stateQ == sfo_pkg::PORT_SHIFT) & sclkRise;
   assign lastEdge = shiftStep & (bitQ == LAST_BIT);
   // Popping at the start frees a slot a whole word earlier
   assign fifoPop = (stateQ == sfo_pkg::PORT_IDLE) & startReq;
   assign leadEnd = waitEnd(stateQ, sfo_pkg::PORT_LEAD, waitQ, LEAD_N);
   assign tailEnd = waitEnd(stateQ, sfo_pkg::PORT_TAIL, waitQ, TAIL_N);
   assign tokenEnd = waitEnd(stateQ, sfo_pkg::PORT_TOKEN, waitQ, TOKEN_LAST);
   // Gap before the pulse keeps the token clear of the ready edge
   assign tokenWindow = (stateQ == sfo_pkg::PORT_TOKEN) && (waitQ >= GAP_N) &&
                        (waitQ < TOKEN_LAST);
   // Line forced low outside a word, so no stale bit is ever shown
   assign lineActive = (stateQ == sfo_pkg::PORT_LEAD) || (stateQ == sfo_pkg::PORT_SHIFT) ||
                       (stateQ == sfo_pkg::PORT_TAIL);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stateQ <= sfo_pkg::PORT_IDLE;
      end else begin
         unique case (stateQ)
            sfo_pkg::PORT_IDLE: begin
               if (startReq) begin
                  stateQ <= sfo_pkg::PORT_LEAD; // [R04]
               end
            end
            sfo_pkg::PORT_LEAD: begin
               if (leadEnd) begin
                  stateQ <= sfo_pkg::PORT_SHIFT;
               end
            end
            sfo_pkg::PORT_SHIFT: begin
               if (lastEdge) begin
                  stateQ <= sfo_pkg::PORT_TAIL;
               end
            end
            sfo_pkg::PORT_TAIL: begin
               if (tailEnd) begin
                  stateQ <= sfo_pkg::PORT_TOKEN; // [R06]
               end
            end
            sfo_pkg::PORT_TOKEN: begin
               if (tokenEnd) begin
                  stateQ <= sfo_pkg::PORT_IDLE;
               end
            end
            default: begin
               stateQ <= sfo_pkg::PORT_IDLE;
            end
         endcase
      end
   end

   // Wait counter starts from zero in each timed state
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         waitQ <= '0;
      end else if (leadEnd || tailEnd || stateQ == sfo_pkg::PORT_IDLE ||
                   stateQ == sfo_pkg::PORT_SHIFT) begin
         waitQ <= '0;
      end else begin
         waitQ <= waitQ + 1'b1;
      end
   end

   // =====================================
   // Shift register, MSB first
   // Shifting on the synchronised rising edge keeps the old bit for the
   // synchroniser delay, which gives the hold after the edge; the new bit
   // then stands for the rest of the period as setup for the next one.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         shiftQ <= `SFO_WORD_RST;
         bitQ <= '0;
      end else if (fifoPop) begin
         shiftQ <= headWord; // [R03]
         bitQ <= '0;
      end else if (shiftStep) begin
         shiftQ <= {shiftQ[`SFO_WORD_W-2:0], 1'b0}; // [R05]
         bitQ <= bitQ + 1'b1;
      end
   end

   // =====================================
   // Pin outputs
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         word_ready_n <= 1'b1;
      end else if (leadEnd) begin
         word_ready_n <= 1'b0; // [R04]
      end else if (tailEnd) begin
         word_ready_n <= 1'b1; // [R06]
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         serial_sample_line <= 1'b0;
      end else if (lineActive) begin
         serial_sample_line <= shiftQ[`SFO_WORD_W-1]; // [R05]
      end else begin
         serial_sample_line <= 1'b0; // [R06]
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         transfer_token_out <= 1'b0;
      end else if (tokenWindow) begin
         transfer_token_out <= 1'b1; // [R07]
      end else begin
         transfer_token_out <= 1'b0;
      end
   end
endmodule

// ---- src/sfo_skid_buf.sv ----
// Two-entry valid/ready buffer on the sample path
`timescale 1ns/1ps
module sfo_skid_buf #(
   parameter int WIDTH = 32
) (
   input wire logic ref_clk, // Clock
   input wire logic rst, // Async reset, active high
   input wire logic inValid, // Upstream word valid
   output logic inReady, // Buffer can take a word
   input wire logic [WIDTH-1:0] inData, // Upstream word
   output logic outValid, // Word on output
   input wire logic outReady, // Downstream takes word
   output logic [WIDTH-1:0] outData // Output word
);
   logic outValidQ;
   logic spareValidQ;
   logic inReadyQ;
   logic [WIDTH-1:0] outDataQ;
   logic [WIDTH-1:0] spareDataQ;
   logic push;
   logic advance;

   assign push = inValid & inReadyQ;
   assign advance = ~outValidQ | outReady;
   assign inReady = inReadyQ;
   assign outValid = outValidQ;
   assign outData = outDataQ;

   // =====================================
   // Main slot
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         outValidQ <= 1'b0;
         outDataQ <= '0;
      end else if (advance) begin
         if (spareValidQ) begin
            outValidQ <= 1'b1;
            outDataQ <= spareDataQ;
         end else begin
            outValidQ <= push;
            if (push) begin
               outDataQ <= inData;
            end
         end
      end
   end

   // =====================================
   // Spare slot catches the word arriving during a stall
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         spareValidQ <= 1'b0;
         spareDataQ <= '0;
         inReadyQ <= 1'b1;
      end else if (advance) begin
         spareValidQ <= 1'b0;
         inReadyQ <= 1'b1;
      end else if (push) begin
         spareValidQ <= 1'b1;
         spareDataQ <= inData;
         inReadyQ <= 1'b0;
      end
   end
endmodule

// ---- tb/sfo_sample_port_bench.sv ----
// Self-checking bench for the sample FIFO serial port
`timescale 1ns/1ps
`include "sfo_defines.svh"
module sfo_sample_port_bench;
   logic ref_clk, rst, sampleValid, sampleReady, timing_event_strobe, collectEn, ok;
   logic transfer_token_in, serial_shift_clock, word_ready_n, serial_sample_line;
   logic transfer_token_out, gotStrobe;
   logic [23:0] sampleData;
   logic [6:0] sampleStatus;
   sfo_pkg::sfo_word_s gotWord;
   logic [31:0] expQ[$];
   int errors, n_tests, seed, i, k, nTok, nWord, nTaken;
   sfo_sample_port sfo_sample_port_i (.ref_clk(ref_clk), .rst(rst), .sampleValid(sampleValid),
      .sampleReady(sampleReady), .sampleData(sampleData), .sampleStatus(sampleStatus),
      .timing_event_strobe(timing_event_strobe), .transfer_token_in(transfer_token_in),
      .serial_shift_clock(serial_shift_clock), .word_ready_n(word_ready_n),
      .serial_sample_line(serial_sample_line), .transfer_token_out(transfer_token_out));
   sfo_telemetry sfo_telemetry_i (.collectEn(collectEn), .word_ready_n(word_ready_n),
      .serial_sample_line(serial_sample_line), .transfer_token_in(transfer_token_in),
      .serial_shift_clock(serial_shift_clock), .gotWord(gotWord), .gotStrobe(gotStrobe));
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // ==========================================================
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test;
      $display("Compares %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Always at least one edge, so valid is never assigned twice in a step
   task automatic idle(input int n);
      sampleValid <= 1'b0;
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic send(input logic ev, input int lim);
      logic [31:0] w;
      w = {ev, 7'($random(seed)), 24'($random(seed))};
      sampleStatus <= w[30:24];
      sampleData <= w[23:0];
      sampleValid <= 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (sampleReady !== 1'b1 && k < lim);
      ok = (sampleReady === 1'b1);
      if (ok) expQ.push_back(w);
   endtask
   always @(posedge gotStrobe) begin
      nWord++;
      if (expQ.size() == 0) chk("unexpected word", 32'h0000_0000, 32'h0000_0001);
      else chk("serial word", expQ.pop_front(), gotWord);
   end
   always @(posedge transfer_token_out) nTok++;
   // ==========================================================
   initial begin
      seed = 32'h86da_2fc3;
      rst = 1'b1;
      sampleValid = 1'b0;
      sampleData = 24'h00_0000;
      sampleStatus = 7'h00;
      timing_event_strobe = 1'b0;
      collectEn = 1'b0;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      collectEn <= 1'b1;
      repeat (80) @(posedge ref_clk);
      chk("ready while empty", 32'h0000_0001, word_ready_n);
      collectEn <= 1'b0;
      repeat (50) @(posedge ref_clk);
      // Telemetry stalled: offer 12 samples, the last ones refused
      for (int j = 0; j < 12; j++) begin
         send(1'b0, 20);
         if (ok) nTaken++;
      end
      idle(1);
      chk("taken while stalled", 32'h0000_0001, nTaken >= `SFO_FIFO_DEPTH && nTaken < 12);
      chk("ready while full", 32'h0000_0000, sampleReady);
      collectEn <= 1'b1;
      timing_event_strobe <= 1'b1;
      repeat (2) @(posedge ref_clk);
      timing_event_strobe <= 1'b0;
      repeat (6) @(posedge ref_clk);
      send(1'b1, 2000);
      chk("flagged sample taken", 32'h0000_0001, ok);
      send(1'b0, 2000);
      chk("plain sample taken", 32'h0000_0001, ok);
      for (i = 0; i < 30; i++) begin
         send(1'b0, 2000);
         chk("sample taken", 32'h0000_0001, ok);
         if (!ok) break;
         if ($random(seed) & 1) idle(1 + ($random(seed) & 255));
      end
      idle(1);
      for (k = 0; k < 30000 && expQ.size() > 0; k++) @(posedge ref_clk);
      repeat (20) @(posedge ref_clk);
      chk("words left", 32'h0000_0000, expQ.size());
      chk("token pulses", nWord, nTok);
      finish_test();
   end
endmodule

// ---- tb/sfo_sample_port_chk.sv ----
// Assertion checker for the sample FIFO serial port
`timescale 1ns/1ps
module sfo_chk #(
   parameter int DEPTH = 8
) (
   input wire logic ref_clk, // Clock
   input wire logic rst, // Reset
   input wire logic sampleValid, // Sample strobe
   input wire logic sampleReady, // Path ready
   input wire logic transfer_token_in, // Token in
   input wire logic serial_shift_clock, // Shift clock
   input wire logic word_ready_n, // Word ready
   input wire logic serial_sample_line, // Data out
   input wire logic transfer_token_out // Token out
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   int cnt;
   logic tokSeenQ;
   // Request seen since the last word ended; a pulsed token may be gone
   // again by the time ready falls, so it is remembered here
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tokSeenQ <= 1'b0;
      end else if (transfer_token_in) begin
         tokSeenQ <= 1'b1;
      end else if ($rose(word_ready_n)) begin
         tokSeenQ <= 1'b0;
      end
   end
   // ==========================================================
   // Fill estimate, never below the true fill: starts lag the pop
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
      end else begin
         cnt <= cnt + int'(sampleValid && sampleReady) - int'($fell(word_ready_n));
      end
   end
   property p_room;
      cnt < DEPTH |-> sampleReady;
   endproperty
   a_room: assert property (p_room) else $error("sample refused with room left");
   property p_no_start_empty;
      $fell(word_ready_n) |-> cnt != 0;
   endproperty
   a_no_start_empty: assert property (p_no_start_empty) else $error("start on empty");
   property p_start_token;
      $fell(word_ready_n) |-> tokSeenQ && !serial_shift_clock;
   endproperty
   a_start_token: assert property (p_start_token) else $error("start without token");
   property p_line_hold;
      $rose(serial_shift_clock) && !word_ready_n |->
         $stable(serial_sample_line) ##1 $stable(serial_sample_line);
   endproperty
   a_line_hold: assert property (p_line_hold) else $error("bit moved at shift edge");
   property p_rdy_min_low;
      $fell(word_ready_n) |-> !word_ready_n [*8];
   endproperty
   a_rdy_min_low: assert property (p_rdy_min_low) else $error("word cut short");
   property p_line_idle;
      $rose(word_ready_n) |-> !serial_sample_line [*4];
   endproperty
   a_line_idle: assert property (p_line_idle) else $error("line driven after word");
   property p_tok_after_rdy;
      $rose(word_ready_n) |-> ##[1:3] $rose(transfer_token_out);
   endproperty
   a_tok_after_rdy: assert property (p_tok_after_rdy) else $error("no token out");
   property p_tok_width;
      $rose(transfer_token_out) |-> transfer_token_out [*4] ##1 !transfer_token_out;
   endproperty
   a_tok_width: assert property (p_tok_width) else $error("token out width");
   property p_tok_rdy_high;
      transfer_token_out |-> word_ready_n;
   endproperty
   a_tok_rdy_high: assert property (p_tok_rdy_high) else $error("token during word");
endmodule
bind sfo_sample_port sfo_chk #(.DEPTH(DEPTH)) sfo_chk_i (.ref_clk(ref_clk), .rst(rst),
   .sampleValid(sampleValid), .sampleReady(sampleReady), .transfer_token_in(transfer_token_in),
   .serial_shift_clock(serial_shift_clock), .word_ready_n(word_ready_n),
   .serial_sample_line(serial_sample_line), .transfer_token_out(transfer_token_out));

// ---- tb/sfo_telemetry.sv ----
// Telemetry model collecting words from the serial port
`timescale 1ns/1ps
module sfo_telemetry (
   input wire logic collectEn, // Collect while high
   input wire logic word_ready_n, // Device word ready
   input wire logic serial_sample_line, // Device data
   output logic transfer_token_in, // Request token
   output logic serial_shift_clock, // Shift clock
   output sfo_pkg::sfo_word_s gotWord, // Last word
   output logic gotStrobe // Pulse per word
);
   int i;
   // ==========================================================
   // Free-running phase offset from the device clock on purpose
   initial begin
      transfer_token_in = 1'b0;
      serial_shift_clock = 1'b0;
      gotWord = 32'h0000_0000;
      gotStrobe = 1'b0;
      forever begin
         #3;
         if (collectEn) begin
            transfer_token_in = 1'b1;
            for (i = 0; i < 40 && word_ready_n; i++) #25;
            transfer_token_in = 1'b0;
            if (!word_ready_n) begin
               #100;
               for (i = 0; i < 32; i++) begin
                  serial_shift_clock = 1'b1;
                  gotWord = {gotWord[30:0], serial_sample_line};
                  #100 serial_shift_clock = 1'b0;
                  #100;
               end
               for (i = 0; i < 40 && !word_ready_n; i++) #25;
               gotStrobe = 1'b1;
               #25 gotStrobe = 1'b0;
            end
         end
      end
   end
endmodule
